// ===== verif/rwc_props.sv
`timescale 1ns/1ps
`default_nettype none
module rwc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  input wire rwc_pkg::rwc_r2c_t redist_to_cpuif_msg,
  input wire rwc_pkg::rwc_c2r_t cpuif_to_redist_msg
);
  import rwc_pkg::*;
  logic lp_h;
  logic take;
  assign take = reg_req && !reg_ack;
  // low-power request as last written over the link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_h <= LPR_RST;
    end else if (take && reg_wr) begin
      lp_h <= reg_wdata[LPR_BIT];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ack_next: assert property (take |=> reg_ack)
    else $error("register ack late");
  a_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("register ack too long");
  a_req_hold: assert property (take |=> reg_req && $stable(reg_wr) && $stable(reg_wdata))
    else $error("register request dropped early");
  a_rsvd_zero: assert property (reg_ack && !reg_wr
    |-> reg_rdata[31:3] == '0 && !reg_rdata[0])
    else $error("reserved bits not zero");
  a_rd_lowpower: assert property (reg_ack && !reg_wr && lp_h == $past(lp_h, 3)
    |-> reg_rdata[LPR_BIT] == lp_h)
    else $error("low-power bit wrong");
  a_no_fwd_sleep: assert property (lp_h && $past(lp_h, 3)
    |-> redist_to_cpuif_msg != R2C_INT)
    else $error("interrupt forwarded while asleep");
  a_quiesce_sent: assert property (take && reg_wr && reg_wdata[LPR_BIT] && !lp_h
    |-> ##[1:4] redist_to_cpuif_msg == R2C_QUIESCE)
    else $error("no quiesce after sleep request");
  a_qack_follows: assert property (redist_to_cpuif_msg == R2C_QUIESCE
    |-> ##[1:60] cpuif_to_redist_msg == C2R_QACK)
    else $error("quiesce never acknowledged");
  c_quiesce: cover property (redist_to_cpuif_msg == R2C_QUIESCE);
  c_release: cover property (cpuif_to_redist_msg == C2R_RELEASE);
  c_forward: cover property (redist_to_cpuif_msg == R2C_INT);
  c_quiet_rd: cover property (reg_ack && !reg_wr && reg_rdata[QUI_BIT]);
endmodule : rwc_props
`default_nettype wire

// ===== verif/rwc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rwc_tb;
  import rwc_pkg::*;
  logic aclk, aresetn, two_sec, irq_v, awv, wv, bre, arv, rre, take;
  logic aw_rdy, w_rdy, bv, ar_rdy, rv, cpu_v, lp_req, quiesced;
  logic [4:0] irq_id, cpu_id;
  logic [31:0] awa, wd, ara, rdat, held, m, got;
  logic [1:0] br, rr, rsp;
  int failures, n_checks, seed;
  rwc_if lnk();
  rwc_redist rwc_redist_i(.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
    .two_sec_states(two_sec), .irq_valid(irq_v), .irq_id(irq_id),
    .lp_req(lp_req), .quiesced(quiesced), .held(held));
  rwc_ctrl rwc_ctrl_i(.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
    .s_axi_awvalid(awv), .s_axi_awready(aw_rdy), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .cpu_irq_valid(cpu_v), .cpu_irq_id(cpu_id), .cpu_irq_take(take));
  rwc_props rwc_props_i(.aclk(aclk), .aresetn(aresetn), .reg_req(lnk.reg_req),
    .reg_wr(lnk.reg_wr), .reg_wdata(lnk.reg_wdata), .reg_ack(lnk.reg_ack),
    .reg_rdata(lnk.reg_rdata), .redist_to_cpuif_msg(lnk.redist_to_cpuif_msg),
    .cpuif_to_redist_msg(lnk.cpuif_to_redist_msg));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awv <= 1'b1;
    awa <= {28'h0, a};
    wv <= 1'b1;
    wd <= d;
    bre <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_rdy) awv <= 1'b0;
      if (w_rdy) wv <= 1'b0;
      if (bv) break;
    end
    rsp = br;
    bre <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= {28'h0, a};
    rre <= 1'b1;
    forever begin
      @(posedge aclk);
      if (ar_rdy) arv <= 1'b0;
      if (rv) break;
    end
    d = rdat;
    rsp = rr;
    rre <= 1'b0;
  endtask : rd_reg
  // expected pending set grows by one id per arrival
  function automatic logic [31:0] onehot(input logic [4:0] i);
    return 32'h0000_0001 << i;
  endfunction : onehot
  // arrival pulse; expected set kept in m
  task automatic irq(input logic [4:0] i);
    @(posedge aclk);
    irq_v <= 1'b1;
    irq_id <= i;
    m = m | onehot(i);
    @(posedge aclk);
    irq_v <= 1'b0;
  endtask : irq
  task automatic burst(input int n);
    repeat (n) irq(5'($random(seed)));
  endtask : burst
  task automatic wait_for(input logic lp, input logic q);
    int t;
    t = 0;
    while (!(lp_req === lp && quiesced === q) && t < 300) begin
      @(posedge aclk);
      t++;
    end
    #1;
    chk("lp_req", lp_req, lp);
    chk("quiesced", quiesced, q);
  endtask : wait_for
  // cpu side takes at random moments
  task automatic drain(output logic [31:0] g);
    g = '0;
    repeat (80) begin
      @(posedge aclk);
      if (cpu_v === 1'b1 && take === 1'b1) g[cpu_id] = 1'b1;
      take <= 1'($random(seed));
    end
    @(posedge aclk);
    if (cpu_v === 1'b1 && take === 1'b1) g[cpu_id] = 1'b1;
    take <= 1'b0;
  endtask : drain
  task automatic wake_all;
    wr_reg(CTRL_OFF, 32'h2);
    wait_for(1'b0, 1'b0);
    wr_reg(GRPEN_OFF, 32'h3);
    drain(got);
    chk("taken", got, m);
    chk("held", held, 0);
    chk("wake", lnk.wake_out_req, 0);
    m = '0;
  endtask : wake_all
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    test_done();
  end
  initial begin
    seed = 32'h76fe372e;
    {aresetn, irq_v, awv, wv, bre, arv, rre, take} = '0;
    two_sec = 1'b1;
    irq_id = '0;
    {awa, wd, ara} = '0;
    m = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("lp_req", lp_req, LPR_RST);
    chk("quiesced", quiesced, QUI_RST);
    chk("wake", lnk.wake_out_req, 0);
    rd_reg(GRPEN_OFF, got);
    chk("grpen", got, GRPEN_RST);
    rd_reg(4'hc, got);
    chk("rd resp", rsp, RESP_SLVERR);
    wr_reg(4'hc, 32'h1);
    chk("wr resp", rsp, RESP_SLVERR);
    $display("test reset done");
    burst(4);
    irq(5'd0);
    irq(5'd31);
    repeat (3) @(posedge aclk);
    #1;
    chk("held", held, m);
    chk("cpu irq", cpu_v, 0);
    chk("wake", lnk.wake_out_req, 1);
    rd_reg(STAT_OFF, got);
    chk("st wake", got[ST_WAKE_BIT], 1);
    wake_all();
    $display("test sleep arrivals done");
    burst(5);
    drain(got);
    chk("taken", got, m);
    chk("wake", lnk.wake_out_req, 0);
    m = '0;
    $display("test awake traffic done");
    wr_reg(CTRL_OFF, 32'h1);
    rd_reg(STAT_OFF, got);
    chk("err", got[ST_ERR_BIT], 1);
    chk("lp_req", lp_req, 0);
    wr_reg(STAT_OFF, 32'h8);
    rd_reg(STAT_OFF, got);
    chk("err", got[ST_ERR_BIT], 0);
    $display("test refused sleep done");
    burst(6);
    repeat (6) @(posedge aclk);
    wr_reg(GRPEN_OFF, 32'h0);
    wr_reg(CTRL_OFF, 32'h1);
    wait_for(1'b1, 1'b1);
    chk("held", held, m);
    chk("cpu irq", cpu_v, 0);
    irq(5'd17);
    repeat (3) @(posedge aclk);
    #1;
    chk("wake", lnk.wake_out_req, 1);
    wake_all();
    $display("test release done");
    test_done();
  end
endmodule : rwc_tb
`default_nettype wire

// ===== verilog/rwc_ctrl.sv
// Contract
// - low-power set: arriving interrupts raise wake request
// - low-power set: hold interrupts, never forward (code still forwards one picked in the cycle the request is written)
// - entering low power releases cpu-side pending interrupts
// - quiesced flag bit 2, one when links quiet
// - bit 1 low-power request: 0 awake, 1 sleeping
// - reset sets quiesced and low-power request
// - software sets request, polls until quiesced one
// - software clears request, waits quiesced zero
// - clear request only while quiesced reads one
// - set request only with group enables zero
// - two security states: non-secure reads zero, writes dropped
// - wake register 32 bits, reserved bits zero
// - wake register at offset 0x0014
// - quiesce command and release command on link
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rwc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  rwc_if.ctrl lnk,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic cpu_irq_valid,
  output logic [rwc_pkg::IDW-1:0] cpu_irq_id,
  input wire logic cpu_irq_take
);
  import rwc_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SLP_WR = 3'b001, H_SLP_POLL = 3'b010,
    H_WK_CHK = 3'b011, H_WK_WR = 3'b100, H_WK_POLL = 3'b101
  } rwc_hs_t;

  typedef struct packed {
    rwc_hs_t hs;
    logic req;
    logic wr;
    logic lpr_wr;
    logic asleep;
    logic err;
    logic [GRPEN_W-1:0] grpen;
    logic [NIRQ-1:0] cpend;
    logic qmode;
    rwc_c2r_t cmsg;
    logic [IDW-1:0] cid;
    logic irq_v;
    logic [IDW-1:0] irq_id;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rwc_hst_t;

  localparam rwc_hst_t H_RST = '{
    hs: H_IDLE, asleep: 1'b1, grpen: GRPEN_RST, cmsg: C2R_NONE, default: '0
  };

  rwc_hst_t state_reg;
  rwc_hst_t state_next;
  logic [IDW-1:0] cidx;

  always_comb begin
    state_next = state_reg;
    state_next.cmsg = C2R_NONE;
    state_next.cid = '0;
    cidx = rwc_first(state_reg.cpend);
    // register port sequencer
    if (state_reg.hs != H_IDLE && !state_reg.req && !lnk.reg_ack) begin
      state_next.req = 1'b1;
      state_next.wr = (state_reg.hs == H_SLP_WR) || (state_reg.hs == H_WK_WR);
      state_next.lpr_wr = (state_reg.hs == H_SLP_WR);
    end
    if (lnk.reg_ack) begin
      state_next.req = 1'b0;
      case (state_reg.hs)
        H_SLP_WR: state_next.hs = H_SLP_POLL;
        H_SLP_POLL: begin
          if (lnk.reg_rdata[QUI_BIT]) begin
            state_next.hs = H_IDLE;
            state_next.asleep = 1'b1;
          end
        end
        H_WK_CHK: begin
          if (lnk.reg_rdata[QUI_BIT]) begin
            state_next.hs = H_WK_WR;
          end
        end
        H_WK_WR: state_next.hs = H_WK_POLL;
        H_WK_POLL: begin
          if (!lnk.reg_rdata[QUI_BIT]) begin
            state_next.hs = H_IDLE;
            state_next.asleep = 1'b0;
          end
        end
        default: state_next.hs = H_IDLE;
      endcase
    end
    // cpu interface end of the link
    if (cpu_irq_take && state_reg.irq_v) begin
      state_next.cpend[state_reg.irq_id] = 1'b0;
    end
    if (state_reg.qmode) begin
      if (|state_reg.cpend) begin
        state_next.cmsg = C2R_RELEASE;
        state_next.cid = cidx;
        state_next.cpend[cidx] = 1'b0;
      end else begin
        state_next.cmsg = C2R_QACK;
        state_next.qmode = 1'b0;
      end
    end
    if (lnk.redist_to_cpuif_msg == R2C_QUIESCE) begin
      state_next.qmode = 1'b1;
    end
    if (lnk.redist_to_cpuif_msg == R2C_INT) begin
      state_next.cpend[lnk.r2c_id] = 1'b1;
    end
    state_next.irq_v = (|state_next.cpend) && (|state_next.grpen) && !state_next.qmode;
    state_next.irq_id = rwc_first(state_next.cpend);
    // axi4-lite write
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (state_reg.awaddr == CTRL_OFF) begin
        if (state_reg.wstrb[0] && state_reg.wdata[CMD_SLEEP_BIT]) begin
          if (state_reg.hs != H_IDLE || state_next.grpen != '0) begin
            state_next.err = 1'b1;
          end else begin
            state_next.hs = H_SLP_WR;
          end
        end else if (state_reg.wstrb[0] && state_reg.wdata[CMD_WAKE_BIT]) begin
          if (state_reg.hs != H_IDLE) begin
            state_next.err = 1'b1;
          end else begin
            state_next.hs = H_WK_CHK;
          end
        end
      end else if (state_reg.awaddr == STAT_OFF) begin
        if (state_reg.wstrb[0] && state_reg.wdata[ST_ERR_BIT]) begin
          state_next.err = 1'b0;
        end
      end else if (state_reg.awaddr == GRPEN_OFF) begin
        if (state_reg.wstrb[0]) begin
          state_next.grpen = state_reg.wdata[GRPEN_W-1:0];
        end
      end else begin
        state_next.bresp = RESP_SLVERR;
      end
    end
    state_next.awready = !state_next.aw_got && !state_next.bvalid;
    state_next.wready = !state_next.w_got && !state_next.bvalid;
    // axi4-lite read
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = 32'h0000_0000;
      state_next.rresp = RESP_OKAY;
      if (s_axi_araddr[3:0] == STAT_OFF) begin
        state_next.rdata[ST_BUSY_BIT] = (state_reg.hs != H_IDLE);
        state_next.rdata[ST_ASLEEP_BIT] = state_reg.asleep;
        state_next.rdata[ST_WAKE_BIT] = lnk.wake_out_req;
        state_next.rdata[ST_ERR_BIT] = state_reg.err;
      end else if (s_axi_araddr[3:0] == GRPEN_OFF) begin
        state_next.rdata[GRPEN_W-1:0] = state_reg.grpen;
      end else if (s_axi_araddr[3:0] != CTRL_OFF) begin
        state_next.rresp = RESP_SLVERR;
      end
    end
    state_next.arready = !state_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= H_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lnk.reg_req = state_reg.req;
  assign lnk.reg_wr = state_reg.wr;
  assign lnk.reg_secure = 1'b1;
  assign lnk.reg_addr = WAKE_OFF;
  assign lnk.reg_wdata = 32'(state_reg.lpr_wr) << LPR_BIT;
  assign lnk.cpuif_to_redist_msg = state_reg.cmsg;
  assign lnk.c2r_id = state_reg.cid;
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign cpu_irq_valid = state_reg.irq_v;
  assign cpu_irq_id = state_reg.irq_id;
endmodule : rwc_ctrl
`default_nettype wire

// ===== verilog/rwc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rwc_if;
  import rwc_pkg::*;
  logic reg_req;
  logic reg_wr;
  logic reg_secure;
  logic [RAW-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_ack;
  logic [31:0] reg_rdata;
  rwc_r2c_t redist_to_cpuif_msg;
  logic [IDW-1:0] r2c_id;
  rwc_c2r_t cpuif_to_redist_msg;
  logic [IDW-1:0] c2r_id;
  logic wake_out_req;
  modport redist (
    input reg_req, reg_wr, reg_secure, reg_addr, reg_wdata, cpuif_to_redist_msg, c2r_id,
    output reg_ack, reg_rdata, redist_to_cpuif_msg, r2c_id, wake_out_req
  );
  modport ctrl (
    output reg_req, reg_wr, reg_secure, reg_addr, reg_wdata, cpuif_to_redist_msg, c2r_id,
    input reg_ack, reg_rdata, redist_to_cpuif_msg, r2c_id, wake_out_req
  );
endinterface : rwc_if
`default_nettype wire

// ===== verilog/rwc_pkg.sv
`default_nettype none
package rwc_pkg;
  localparam int unsigned NIRQ = 32;
  localparam int unsigned IDW = 5;
  localparam int unsigned RAW = 12;
  localparam logic [RAW-1:0] WAKE_OFF = 12'h014;
  localparam int unsigned LPR_BIT = 1;
  localparam int unsigned QUI_BIT = 2;
  localparam logic LPR_RST = 1'b1;
  localparam logic QUI_RST = 1'b1;
  typedef enum logic [1:0] {
    R2C_NONE = 2'b00, R2C_INT = 2'b01, R2C_QUIESCE = 2'b10
  } rwc_r2c_t;
  typedef enum logic [1:0] {
    C2R_NONE = 2'b00, C2R_RELEASE = 2'b01, C2R_QACK = 2'b10
  } rwc_c2r_t;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam logic [3:0] GRPEN_OFF = 4'h8;
  localparam int unsigned CMD_SLEEP_BIT = 0;
  localparam int unsigned CMD_WAKE_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_ASLEEP_BIT = 1;
  localparam int unsigned ST_WAKE_BIT = 2;
  localparam int unsigned ST_ERR_BIT = 3;
  localparam int unsigned GRPEN_W = 2;
  localparam logic [GRPEN_W-1:0] GRPEN_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // index of the lowest set bit, zero when none set
  function automatic logic [IDW-1:0] rwc_first(input logic [NIRQ-1:0] v);
    logic [IDW-1:0] idx;
    idx = '0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IDW'(i);
      end
    end
    return idx;
  endfunction : rwc_first
endpackage : rwc_pkg
`default_nettype wire

// ===== verilog/rwc_redist.sv
`timescale 1ns/1ps
`default_nettype none
module rwc_redist (
  input wire logic aclk,
  input wire logic aresetn,
  rwc_if.redist lnk,
  input wire logic two_sec_states,
  input wire logic irq_valid,
  input wire logic [rwc_pkg::IDW-1:0] irq_id,
  output logic lp_req,
  output logic quiesced,
  output logic [rwc_pkg::NIRQ-1:0] held
);
  import rwc_pkg::*;

  typedef enum logic [1:0] {
    RD_AWAKE = 2'b00,
    RD_QUIESCE = 2'b01,
    RD_WAITACK = 2'b10,
    RD_ASLEEP = 2'b11
  } rwc_rd_state_t;

  typedef struct packed {
    rwc_rd_state_t st;
    logic lpr;
    logic qui;
    logic [NIRQ-1:0] pend;
    logic wake;
    logic ack;
    logic [31:0] rdata;
    rwc_r2c_t msg;
    logic [IDW-1:0] msg_id;
  } rwc_rd_t;

  localparam rwc_rd_t RD_RST = '{
    st: RD_ASLEEP,
    lpr: LPR_RST,
    qui: QUI_RST,
    pend: '0,
    wake: 1'b0,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    msg: R2C_NONE,
    msg_id: '0
  };

  rwc_rd_t state_reg;
  rwc_rd_t state_next;
  logic sec_ok;
  logic hit;
  logic [IDW-1:0] idx;

  always_comb begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.msg = R2C_NONE;
    state_next.msg_id = '0;
    sec_ok = !two_sec_states || lnk.reg_secure;
    hit = (lnk.reg_addr == WAKE_OFF);
    idx = rwc_first(state_reg.pend);
    // register port: one ack cycle per request
    if (lnk.reg_req && !state_reg.ack) begin
      state_next.ack = 1'b1;
      state_next.rdata = 32'h0000_0000;
      if (sec_ok && hit) begin
        if (lnk.reg_wr) begin
          state_next.lpr = lnk.reg_wdata[LPR_BIT];
        end else begin
          state_next.rdata[LPR_BIT] = state_reg.lpr;
          state_next.rdata[QUI_BIT] = state_reg.qui;
        end
      end
    end
    case (state_reg.st)
      RD_AWAKE: begin
        if (state_reg.lpr) begin
          state_next.st = RD_QUIESCE;
        end else if (|state_reg.pend) begin
          state_next.msg = R2C_INT;
          state_next.msg_id = idx;
          state_next.pend[idx] = 1'b0;
        end
      end
      RD_QUIESCE: begin
        // hold everything and ask the cpu side to hand back its pending set
        state_next.msg = R2C_QUIESCE;
        state_next.st = RD_WAITACK;
      end
      RD_WAITACK: begin
        if (lnk.cpuif_to_redist_msg == C2R_QACK) begin
          state_next.st = RD_ASLEEP;
          state_next.qui = 1'b1;
        end
      end
      RD_ASLEEP: begin
        // relies on request being cleared only while quiesced
        if (!state_reg.lpr) begin
          state_next.st = RD_AWAKE;
          state_next.qui = 1'b0;
        end
      end
      default: begin
        state_next.st = RD_ASLEEP;
      end
    endcase
    // returned and arriving interrupts win over the forward clear
    if (lnk.cpuif_to_redist_msg == C2R_RELEASE) begin
      state_next.pend[lnk.c2r_id] = 1'b1;
    end
    if (irq_valid) begin
      state_next.pend[irq_id] = 1'b1;
    end
    state_next.wake = (|state_next.pend) && (state_reg.lpr || state_reg.wake);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= RD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lnk.reg_ack = state_reg.ack;
  assign lnk.reg_rdata = state_reg.rdata;
  assign lnk.redist_to_cpuif_msg = state_reg.msg;
  assign lnk.r2c_id = state_reg.msg_id;
  assign lnk.wake_out_req = state_reg.wake;
  assign lp_req = state_reg.lpr;
  assign quiesced = state_reg.qui;
  assign held = state_reg.pend;
endmodule : rwc_redist
`default_nettype wire
